// File: verilog/vtr_pkg.sv
/*
  vtr_pkg: constants for the vector table relocation block.
  Assumes word-addressed program flash with a 16-bit word address.
*/
`default_nettype none
package vtr_pkg;
  localparam int          ADDR_W           = 16;
  localparam logic [7:0]  CTRL_OFFSET      = 8'h00;
  localparam logic [7:0]  CTRL_RESET       = 8'h00;
  localparam int          UNLOCK_BIT       = 0;
  localparam int          SELECT_BIT       = 1;
  localparam int          PULLUP_BIT       = 4;
  localparam int          SPS_BIT          = 7;
  localparam logic [7:0]  CTRL_WMASK       = 8'h92;
  localparam int          UNLOCK_CYCLES    = 4;
  localparam logic [2:0]  UNLOCK_LAST      = 3'h4;
  localparam logic [15:0] VEC_OFFSET       = 16'h0002;
  localparam logic [15:0] APP_VEC_BASE     = 16'h0000;
  localparam logic [15:0] RESET_APP        = 16'h0000;
  localparam logic [15:0] BOOT_START_512W  = 16'h0e00;
  localparam logic [15:0] BOOT_START_1KW   = 16'h0c00;
  localparam logic [15:0] BOOT_START_2KW   = 16'h0800;
  localparam logic [15:0] BOOT_START_4KW   = 16'h0000;
endpackage : vtr_pkg
`default_nettype wire

// File: verilog/vtr_top.sv
/*
  vtr_top: vector table placement, reset entry and timed unlock of the
  vector select bit, plus dispatch blocking during the unlock sequence.
  Assumes the core signals instr_done once per retired instruction and
  reports the current fetch address; fuses are static.
*/
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module vtr_top (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  input  wire logic [1:0]  boot_size_fuses,
  input  wire logic        boot_reset_fuse_n,
  input  wire logic        app_section_lock_bit_n,
  input  wire logic        boot_section_lock_bit_n,
  input  wire logic [15:0] fetch_addr,
  input  wire logic        instr_done,
  input  wire logic        global_int_enable,
  output logic             dispatch_allow,
  output logic      [15:0] vector_base,
  output logic      [15:0] reset_vector,
  output logic             vector_table_select,
  output logic             vector_change_unlock,
  output logic             serial_pin_select,
  output logic             pullup_disable
);
  typedef enum logic [2:0] {
    VTR_IDLE   = 3'b001,
    VTR_OPEN   = 3'b010,
    VTR_TRAIL  = 3'b100
  } vtr_state_t;

  vtr_state_t  state;
  vtr_state_t  next_state;
  logic [2:0]  count;
  logic [2:0]  next_count;
  logic [7:0]  ctrl;
  logic [7:0]  next_ctrl;
  logic [7:0]  next_rdata;
  logic [15:0] boot_start;
  logic        ctrl_wr;
  logic        in_boot;
  logic        lock_block;

  // fuse decode of boot start, shared by vectors and reset entry
  function automatic logic [15:0] vtr_boot_start(input logic [1:0] sz);
    logic [15:0] r;
    r = vtr_pkg::BOOT_START_4KW;
    unique case (sz)
      2'h3: r = vtr_pkg::BOOT_START_512W;
      2'h2: r = vtr_pkg::BOOT_START_1KW;
      2'h1: r = vtr_pkg::BOOT_START_2KW;
      2'h0: r = vtr_pkg::BOOT_START_4KW;
    endcase
    return r;
  endfunction : vtr_boot_start

  assign boot_start = vtr_boot_start(boot_size_fuses);
  assign ctrl_wr    = reg_write && (reg_addr == vtr_pkg::CTRL_OFFSET);

  always_comb begin
    next_state = state;
    next_count = count;
    next_ctrl  = ctrl;
    if (ctrl_wr) begin
      next_ctrl[vtr_pkg::PULLUP_BIT] = reg_wdata[vtr_pkg::PULLUP_BIT];
      next_ctrl[vtr_pkg::SPS_BIT] = reg_wdata[vtr_pkg::SPS_BIT];
    end
    unique case (state)
      VTR_IDLE: begin
        if (ctrl_wr && reg_wdata[vtr_pkg::UNLOCK_BIT]) begin
          next_ctrl[vtr_pkg::UNLOCK_BIT] = 1'b1;
          next_state = VTR_OPEN;
          next_count = 3'h1;
        end
      end
      VTR_OPEN: begin
        if (ctrl_wr && !reg_wdata[vtr_pkg::UNLOCK_BIT]) begin
          // select only moves inside the window
          next_ctrl[vtr_pkg::SELECT_BIT] =
            reg_wdata[vtr_pkg::SELECT_BIT];
          next_ctrl[vtr_pkg::UNLOCK_BIT] = 1'b0;
          next_state = VTR_TRAIL;
        end else if (count == vtr_pkg::UNLOCK_LAST) begin
          next_ctrl[vtr_pkg::UNLOCK_BIT] = 1'b0;
          next_state = VTR_IDLE;
        end else begin
          next_count = count + 3'h1;
        end
      end
      VTR_TRAIL: begin
        // hold off dispatch until the next instruction retires
        if (instr_done) begin
          next_state = VTR_IDLE;
        end
      end
      default: begin
        next_state = VTR_IDLE;
        next_ctrl[vtr_pkg::UNLOCK_BIT] = 1'b0;
      end
    endcase
    next_rdata = 8'h00;
    if (reg_read && reg_addr == vtr_pkg::CTRL_OFFSET) begin
      next_rdata = ctrl;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state     <= VTR_IDLE;
      count     <= 3'h0;
      ctrl      <= vtr_pkg::CTRL_RESET;
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      state     <= next_state;
      count     <= next_count;
      ctrl      <= next_ctrl;
      reg_rdata <= next_rdata;
    end
  end

  assign in_boot = (boot_size_fuses != 2'h0) ? (fetch_addr >= boot_start)
                                             : 1'b1;
  assign lock_block =
    (ctrl[vtr_pkg::SELECT_BIT] && !app_section_lock_bit_n && !in_boot)
    || (!ctrl[vtr_pkg::SELECT_BIT] && !boot_section_lock_bit_n
        && in_boot);

  // global enable is only read here, never written back
  assign dispatch_allow = global_int_enable && (state == VTR_IDLE)
                          && !lock_block;

  assign vector_base = ctrl[vtr_pkg::SELECT_BIT]
                     ? 16'(boot_start + vtr_pkg::VEC_OFFSET)
                     : 16'(vtr_pkg::APP_VEC_BASE + vtr_pkg::VEC_OFFSET);
  assign reset_vector = !boot_reset_fuse_n ? boot_start
                                           : vtr_pkg::RESET_APP;
  assign vector_table_select  = ctrl[vtr_pkg::SELECT_BIT];
  assign vector_change_unlock = ctrl[vtr_pkg::UNLOCK_BIT];
  assign serial_pin_select    = ctrl[vtr_pkg::SPS_BIT];
  assign pullup_disable       = ctrl[vtr_pkg::PULLUP_BIT];

  // age of the open window, kept apart from count so that the bound is
  // checked against an independent tally, not the counter it guards
  logic [3:0] open_age;
  logic [3:0] next_open_age;

  always_comb begin
    next_open_age = 4'h0;
    if (state == VTR_OPEN) begin
      next_open_age = open_age + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      open_age <= 4'h0;
    end else if (clk_en) begin
      open_age <= next_open_age;
    end
  end

  sequence unlock_set_s;
    clk_en && state == VTR_IDLE && ctrl_wr && reg_wdata[0];
  endsequence

  sequence select_write_s;
    clk_en && state == VTR_OPEN && ctrl_wr
    && !reg_wdata[vtr_pkg::UNLOCK_BIT];
  endsequence

  sequence trail_exit_s;
    clk_en && state == VTR_TRAIL && instr_done;
  endsequence

  unlock_blocks_a: assert property (
    @(posedge clk) disable iff (reset)
    unlock_set_s |=> !dispatch_allow)
    else $error("dispatch not blocked after unlock");

  unlock_timeout_a: assert property (
    @(posedge clk) disable iff (reset)
    (unlock_set_s ##1 (!ctrl_wr && clk_en) [*4]) |=> !vector_change_unlock)
    else $error("unlock did not expire");

  select_guard_a: assert property (
    @(posedge clk) disable iff (reset)
    (clk_en && state == VTR_IDLE) |=> $stable(vector_table_select))
    else $error("select changed without unlock");

  select_clears_a: assert property (
    @(posedge clk) disable iff (reset)
    select_write_s |=> !vector_change_unlock && state == VTR_TRAIL)
    else $error("unlock not cleared on select write");

  select_takes_a: assert property (
    @(posedge clk) disable iff (reset)
    select_write_s
    |=> vector_table_select == $past(reg_wdata[vtr_pkg::SELECT_BIT]))
    else $error("select write inside window not taken");

  window_bound_a: assert property (
    @(posedge clk) disable iff (reset)
    open_age <= 4'h4)
    else $error("unlock window longer than four cycles");

  open_unlock_a: assert property (
    @(posedge clk) disable iff (reset)
    (state == VTR_OPEN) == vector_change_unlock)
    else $error("unlock bit out of step with window");

  trail_end_a: assert property (
    @(posedge clk) disable iff (reset)
    trail_exit_s |=> state == VTR_IDLE)
    else $error("dispatch block outlived the retired instruction");

  trail_hold_a: assert property (
    @(posedge clk) disable iff (reset)
    (clk_en && state == VTR_TRAIL && !instr_done) |=> !dispatch_allow)
    else $error("dispatch released before instruction retired");

  ienable_gate_a: assert property (
    @(posedge clk) disable iff (reset)
    !global_int_enable |-> !dispatch_allow)
    else $error("dispatch allowed with global enable low");

  app_vector_a: assert property (
    @(posedge clk) disable iff (reset)
    !vector_table_select |-> vector_base == 16'h0002)
    else $error("application vector base wrong");

  boot_vector_a: assert property (
    @(posedge clk) disable iff (reset)
    (vector_table_select && boot_size_fuses == 2'h2)
    |-> vector_base == 16'h0c02)
    else $error("boot vector base wrong");

  boot_reset_a: assert property (
    @(posedge clk) disable iff (reset)
    (!boot_reset_fuse_n && boot_size_fuses == 2'h2)
    |-> reset_vector == 16'h0c00)
    else $error("boot reset address wrong");

  app_reset_a: assert property (
    @(posedge clk) disable iff (reset)
    boot_reset_fuse_n |-> reset_vector == 16'h0000)
    else $error("application reset address wrong");

  lock_app_a: assert property (
    @(posedge clk) disable iff (reset)
    (vector_table_select && !app_section_lock_bit_n && !in_boot)
    |-> !dispatch_allow)
    else $error("interrupt allowed in locked application");

  lock_boot_a: assert property (
    @(posedge clk) disable iff (reset)
    (!vector_table_select && !boot_section_lock_bit_n && in_boot)
    |-> !dispatch_allow)
    else $error("interrupt allowed in locked boot section");

  // read data stands for one cycle only, so a stale value is a fault
  rdata_read_a: assert property (
    @(posedge clk) disable iff (reset)
    (clk_en && reg_read && reg_addr == vtr_pkg::CTRL_OFFSET)
    |=> reg_rdata == $past(ctrl))
    else $error("read data does not match control register");

  rdata_idle_a: assert property (
    @(posedge clk) disable iff (reset)
    (clk_en && !reg_read) |=> reg_rdata == 8'h00)
    else $error("read data not cleared without read");

  reserved_zero_a: assert property (
    @(posedge clk) disable iff (reset)
    (ctrl & ~(vtr_pkg::CTRL_WMASK | 8'h01)) == 8'h00)
    else $error("reserved control bits set");

  // a frozen cycle must not advance the window either
  clk_freeze_a: assert property (
    @(posedge clk) disable iff (reset)
    !clk_en |=> $stable(ctrl) && $stable(state) && $stable(count))
    else $error("state moved while clock enable low");
endmodule : vtr_top
`default_nettype wire

// File: test/vtr_core_model.sv
/* vtr_core_model: stand-in for the core's fetch and retire side.
   Assumes the bench requests each retired instruction through step. */
`timescale 1ns/1ps
`default_nettype none
module vtr_core_model (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        step,
  input  wire logic [15:0] pc,
  output logic      [15:0] fetch_addr,
  output logic             instr_done
);
  // retire only on request, so the end of the dispatch trail is exact
  always_ff @(posedge clk) begin
    fetch_addr <= reset ? 16'h0000 : pc;
    instr_done <= reset ? 1'b0 : step;
  end
endmodule : vtr_core_model
`default_nettype wire

// File: test/tb_top.sv
/* tb_top: self-checking bench for vtr_top.
   Assumes vtr_core_model stands in for the core's fetch and retire side. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {logic [1:0] sz; logic [15:0] bs;} vtr_row_t;
  localparam vtr_row_t ROWS [4] = '{'{2'h0, 16'h0000}, '{2'h1, 16'h0800},
    '{2'h3, 16'h0e00}, '{2'h2, 16'h0c00}};
  logic        clk = 1'b0, reset = 1'b1, step = 1'b0;
  logic        reg_write = 1'b0, reg_read = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [1:0]  boot_size_fuses = 2'h0;
  logic        boot_reset_fuse_n = 1'b1;
  logic        app_section_lock_bit_n = 1'b1, boot_section_lock_bit_n = 1'b1;
  logic [15:0] pc = 16'h0000, fetch_addr, vector_base, reset_vector;
  logic        instr_done, dispatch_allow;
  logic        clk_en = 1'b1, global_int_enable = 1'b1;
  logic        serial_pin_select, pullup_disable;
  logic        vector_table_select, vector_change_unlock;
  int          fail_count = 0, samples_checked = 0, cycles = 0;
  wire logic [15:0] ctl = {13'h0, vector_table_select, vector_change_unlock,
                           dispatch_allow};
  always #5 clk = ~clk;
  vtr_top DUT (.clk, .reset, .clk_en, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .boot_size_fuses, .boot_reset_fuse_n,
    .app_section_lock_bit_n, .boot_section_lock_bit_n, .fetch_addr,
    .instr_done, .global_int_enable, .dispatch_allow, .vector_base,
    .reset_vector, .vector_table_select, .vector_change_unlock,
    .serial_pin_select, .pullup_disable);
  vtr_core_model core (.clk, .reset, .step, .pc, .fetch_addr, .instr_done);
  task automatic wrap_up();
    if (fail_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // strobe stays high on return so back-to-back writes never pulse it twice
  task automatic wr(input logic [7:0] d);
    reg_addr <= 8'h00;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
    @(posedge clk);
  endtask : rd
  task automatic at(input logic [15:0] p, input logic [15:0] e);
    pc <= p;
    repeat (2) @(posedge clk);
    #1 chk("ctl", e, ctl);
    @(posedge clk);
  endtask : at
  task automatic run_rows(input logic s);
    foreach (ROWS[i]) begin
      for (int r = 0; r < 2; r++) begin
        boot_size_fuses <= ROWS[i].sz;
        boot_reset_fuse_n <= r[0];
        #1 chk("reset_vector", r[0] ? 16'h0 : ROWS[i].bs, reset_vector);
        chk("vector_base", s ? ROWS[i].bs + 16'h2 : 16'h2, vector_base);
        @(posedge clk);
      end
    end
  endtask : run_rows
  always @(posedge clk) begin
    if (++cycles == 400) begin
      fail_count++;
      wrap_up();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(8'h00, 8'h00);
    run_rows(1'b0);
    wr(8'h02);
    reg_write <= 1'b0;
    #1 chk("ctl", 16'h1, ctl);
    @(posedge clk);
    wr(8'h01);
    reg_write <= 1'b0;
    for (int k = 0; k < 5; k++) begin
      #1 chk("ctl", k < 4 ? 16'h2 : 16'h1, ctl);
      @(posedge clk);
    end
    wr(8'h01);
    wr(8'h02);
    reg_write <= 1'b0;
    step <= 1'b1;
    #1 chk("ctl", 16'h4, ctl);
    @(posedge clk);
    step <= 1'b0;
    #1 chk("ctl", 16'h4, ctl);
    @(posedge clk);
    #1 chk("ctl", 16'h5, ctl);
    @(posedge clk);
    run_rows(1'b1);
    app_section_lock_bit_n <= 1'b0;
    at(16'h0010, 16'h4);
    at(16'h0c10, 16'h5);
    app_section_lock_bit_n <= 1'b1;
    boot_section_lock_bit_n <= 1'b0;
    wr(8'h01);
    wr(8'h00);
    reg_write <= 1'b0;
    step <= 1'b1;
    @(posedge clk);
    step <= 1'b0;
    at(16'h0c10, 16'h0);
    at(16'h0010, 16'h1);
    wr(8'hfc);
    reg_write <= 1'b0;
    rd(8'h00, 8'h90);
    rd(8'h10, 8'h00);
    #1 chk("pins", 16'h3, {14'h0, serial_pin_select, pullup_disable});
    @(posedge clk);
    global_int_enable <= 1'b0;
    #1 chk("ctl", 16'h0, ctl);
    @(posedge clk);
    global_int_enable <= 1'b1;
    clk_en <= 1'b0;
    wr(8'h01);
    reg_write <= 1'b0;
    #1 chk("ctl", 16'h1, ctl);
    @(posedge clk);
    clk_en <= 1'b1;
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    rd(8'h00, 8'h00);
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
